/* File: design/link_ctrl_defs.vh */
/*
 * register map, field positions, reset values and timing counts of the
 * audio link control block.
 * assumes: included by bare name from the design files.
 */
`ifndef LINK_CTRL_DEFS_VH
`define LINK_CTRL_DEFS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define LINK_CONTROL_SET_ADDR 16'hF700
`define LINK_CONTROL_CLEAR_ADDR 16'hF704
`define LINK_EVENT_STATUS_ADDR 16'hF710
`define LINK_EVENT_CLEAR_ADDR 16'hF714
`define LINK_EVENT_ENABLE_ADDR 16'hF718

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_LINK_ENABLE 0
`define CTRL_SLEEP_FORCE 1
`define CTRL_WAKE_ON 2
`define CTRL_WARM_RESET 3
`define CTRL_MIC_SELECT 4
`define CTRL_DMA_LSB 8
`define CTRL_HALT_LSB 16
`define CTRL_WRITE_MASK 32'h00DFDF1F
`define CTRL_RESET_VALUE 32'h00000000

// ----------------------------------------
// event fields
// ----------------------------------------
`define EVT_WAKE_BIT 2
`define EVT_ERR_LSB 8
`define EVT_CLK_ALIVE_BIT 31
`define EVT_STICKY_MASK 32'h0000DF04
`define EVT_ENABLE_RESET 32'h00000000

// ----------------------------------------
// bus answers and timing
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_PERIOD_PS 8000
`define LINK_CLK_IDLE_NS 1000
`define LINK_CLK_IDLE_CYC ((`LINK_CLK_IDLE_NS * 1000) / `CLK_PERIOD_PS)

`endif

/* File: design/sync2.v */
/*
 * two-flop synchroniser for a bus of independent level signals.
 * assumes: each bit is a slow level or a clock far slower than clk_in.
 */
`timescale 1ns/1ps

module sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // data
    input wire [WIDTH-1:0] d_in,
    output reg [WIDTH-1:0] q_out
);

reg [WIDTH-1:0] meta_r;

always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        meta_r <= {WIDTH{1'b0}};
        q_out <= {WIDTH{1'b0}};
    end else begin
        meta_r <= d_in;
        q_out <= meta_r;
    end
end

endmodule

/* File: design/dma_channel.v */
/*
 * one dma channel: sticky overrun/underrun flag and request gating.
 * assumes: err_in and need_in come from fifo logic on the same clock.
 */
`timescale 1ns/1ps

module dma_channel (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // control
    input wire dma_on_in,
    input wire halt_off_in,
    input wire err_clear_in,
    // fifo side
    input wire need_in,
    input wire err_in,
    // outputs
    output reg err_flag_out,
    output reg dma_req_out
);

wire err_nxt;
wire halted;

// a new error wins over a clear in the same cycle
assign err_nxt = err_in | (err_flag_out & ~err_clear_in);
assign halted = err_nxt & ~halt_off_in;

always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        err_flag_out <= 1'b0;
        dma_req_out <= 1'b0;
    end else begin
        err_flag_out <= err_nxt;
        dma_req_out <= dma_on_in & need_in & ~halted;
    end
end

endmodule

/* File: design/audio_link_controller.v */
/*
 * audio link controller control block: set/clear control pair, per-channel
 * dma enables and error halt, link pin levels, event status and interrupt,
 * reached over an axi4-lite slave.
 * assumes: fifo logic supplies need/error per channel on core_clk_in;
 * sdin and bit clock are asynchronous pins.
 */
`timescale 1ns/1ps
`include "link_ctrl_defs.vh"

// Contract
// - clear bit 23 makes modem receive stop requesting after overrun.
// - clear bit 22 makes modem transmit stop requesting after underrun.
// - clear bit 20 makes audio receive stop requesting after overrun.
// - clear bits 19..16 restore error halt for lfe, center, surround, pcm transmit.
// - clear bits 15/14 disable modem dma; zeros written change nothing.
// - clear bits 12..8 disable audio receive and four transmit dma channels.
// - clear bit 4 returns audio reception to pcm left/right slots.
// - clear bit 3 ends warm reset on the link.
// - clear bit 2 disables wake-up power event from sdin high.
// - clear bit 1 leaves low-power; sync and sdout no longer forced low.
// - clear bit 0 asserts active-low cold reset to codecs.
// - dma disable clears enable bit, stopping service for that slot.
// - set register holds state: reads current value, writing one sets.
// - each channel error stays flagged until software writes one.
module audio_link_controller #(
    parameter ADDR_WIDTH = 16,
    parameter CHANNELS = 7,
    parameter SDIN_WIDTH = 2
) (
    // clock and reset
    input wire core_clk_in,
    input wire arst_n_in,
    // axi4-lite write address
    input wire s_axi_awvalid_in,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr_in,
    output reg s_axi_awready_out,
    // axi4-lite write data
    input wire s_axi_wvalid_in,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    output reg s_axi_wready_out,
    // axi4-lite write response
    output reg s_axi_bvalid_out,
    output reg [1:0] s_axi_bresp_out,
    input wire s_axi_bready_in,
    // axi4-lite read address
    input wire s_axi_arvalid_in,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr_in,
    output reg s_axi_arready_out,
    // axi4-lite read data
    output reg s_axi_rvalid_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    input wire s_axi_rready_in,
    // fifo side, one bit per channel
    input wire [CHANNELS-1:0] dma_need_in,
    input wire [CHANNELS-1:0] dma_err_in,
    output wire [CHANNELS-1:0] dma_req_out,
    // link pins
    input wire bit_clk_in,
    input wire [SDIN_WIDTH-1:0] sdin_in,
    output reg codec_cold_reset_n_out,
    output reg warm_reset_drive_out,
    output reg link_sleep_force_out,
    output reg microphone_input_select_out,
    // interrupts
    output reg link_power_event_irq_out,
    output reg irq_out
);

// ----------------------------------------
// address decode
// ----------------------------------------
localparam SEL_NONE = 3'h0;
localparam SEL_SET = 3'h1;
localparam SEL_CLR = 3'h2;
localparam SEL_STAT = 3'h3;
localparam SEL_ECLR = 3'h4;
localparam SEL_EEN = 3'h5;

function [2:0] reg_sel;
    input [ADDR_WIDTH-1:0] addr;
    reg [15:0] a;
    begin
        a = addr[15:0];
        a[1:0] = 2'h0;
        case (a)
            `LINK_CONTROL_SET_ADDR: reg_sel = SEL_SET;
            `LINK_CONTROL_CLEAR_ADDR: reg_sel = SEL_CLR;
            `LINK_EVENT_STATUS_ADDR: reg_sel = SEL_STAT;
            `LINK_EVENT_CLEAR_ADDR: reg_sel = SEL_ECLR;
            `LINK_EVENT_ENABLE_ADDR: reg_sel = SEL_EEN;
            default: reg_sel = SEL_NONE;
        endcase
    end
endfunction

function [31:0] strb_mask;
    input [3:0] strb;
    begin
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
endfunction

// channel index to bit offset; offset 5 (bit 13/21) is reserved
function integer ch_pos;
    input integer ch;
    begin
        ch_pos = (ch < 5) ? ch : ch + 1;
    end
endfunction

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
reg aw_got_r;
reg w_got_r;
reg [ADDR_WIDTH-1:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire aw_hs;
wire w_hs;
wire do_wr;
wire aw_got_nxt;
wire w_got_nxt;
wire [2:0] wr_sel;
wire [31:0] wr_data;

assign aw_hs = s_axi_awvalid_in & s_axi_awready_out;
assign w_hs = s_axi_wvalid_in & s_axi_wready_out;
assign do_wr = aw_got_r & w_got_r & ~s_axi_bvalid_out;
assign aw_got_nxt = do_wr ? 1'b0 : (aw_hs | aw_got_r);
assign w_got_nxt = do_wr ? 1'b0 : (w_hs | w_got_r);
assign wr_sel = reg_sel(aw_addr_r);
assign wr_data = w_data_r & strb_mask(w_strb_r);

always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        aw_addr_r <= {ADDR_WIDTH{1'b0}};
        w_data_r <= 32'h00000000;
        w_strb_r <= 4'h0;
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out <= 1'b0;
        s_axi_bvalid_out <= 1'b0;
        s_axi_bresp_out <= `RESP_OKAY;
    end else begin
        aw_got_r <= aw_got_nxt;
        w_got_r <= w_got_nxt;
        s_axi_awready_out <= ~aw_got_nxt;
        s_axi_wready_out <= ~w_got_nxt;
        if (aw_hs) begin
            aw_addr_r <= s_axi_awaddr_in;
        end
        if (w_hs) begin
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
        end
        if (do_wr) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end
end

// ----------------------------------------
// control register pair
// ----------------------------------------
reg [31:0] ctrl_r;
reg [31:0] ctrl_nxt;
wire [31:0] set_bits;
wire [31:0] clr_bits;

assign set_bits = (do_wr && wr_sel == SEL_SET) ? (wr_data & `CTRL_WRITE_MASK) : 32'h00000000;
assign clr_bits = (do_wr && wr_sel == SEL_CLR) ? (wr_data & `CTRL_WRITE_MASK) : 32'h00000000;

always @* begin
    // ones clear or set their bit, zeros leave it alone
    ctrl_nxt = (ctrl_r & ~clr_bits) | set_bits;
end

always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        ctrl_r <= `CTRL_RESET_VALUE;
    end else begin
        ctrl_r <= ctrl_nxt;
    end
end

// ----------------------------------------
// link pin levels
// ----------------------------------------
always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        codec_cold_reset_n_out <= 1'b0;
        warm_reset_drive_out <= 1'b0;
        link_sleep_force_out <= 1'b0;
        microphone_input_select_out <= 1'b0;
    end else begin
        codec_cold_reset_n_out <= ctrl_nxt[`CTRL_LINK_ENABLE];
        warm_reset_drive_out <= ctrl_nxt[`CTRL_WARM_RESET];
        link_sleep_force_out <= ctrl_nxt[`CTRL_SLEEP_FORCE];
        microphone_input_select_out <= ctrl_nxt[`CTRL_MIC_SELECT];
    end
end

// ----------------------------------------
// pin synchronisers and link clock watch
// ----------------------------------------
localparam IDLE_W = 8;
localparam integer IDLE_CYC = `LINK_CLK_IDLE_CYC;
localparam [IDLE_W-1:0] IDLE_MAX = IDLE_CYC[IDLE_W-1:0];
wire [SDIN_WIDTH-1:0] sdin_s;
wire bclk_s;
reg bclk_d_r;
reg [IDLE_W-1:0] idle_cnt_r;
reg clk_alive_r;

sync2 #(
    .WIDTH(SDIN_WIDTH + 1)
) u_pin_sync (
    .clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .d_in({bit_clk_in, sdin_in}),
    .q_out({bclk_s, sdin_s})
);

always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        bclk_d_r <= 1'b0;
        idle_cnt_r <= {IDLE_W{1'b0}};
        clk_alive_r <= 1'b0;
    end else begin
        bclk_d_r <= bclk_s;
        if (bclk_s & ~bclk_d_r) begin
            idle_cnt_r <= {IDLE_W{1'b0}};
            clk_alive_r <= 1'b1;
        end else if (idle_cnt_r == IDLE_MAX) begin
            clk_alive_r <= 1'b0;
        end else begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end
end

// ----------------------------------------
// dma channels
// ----------------------------------------
wire [CHANNELS-1:0] err_flags;
wire [31:0] err_word;
wire [31:0] evt_clr_bits;

genvar gi;
generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
        localparam integer POS = ch_pos(gi);
        dma_channel u_ch (
            .clk_in(core_clk_in),
            .arst_n_in(arst_n_in),
            .dma_on_in(ctrl_r[`CTRL_DMA_LSB + POS]),
            .halt_off_in(ctrl_r[`CTRL_HALT_LSB + POS]),
            .err_clear_in(evt_clr_bits[`EVT_ERR_LSB + POS]),
            .need_in(dma_need_in[gi]),
            .err_in(dma_err_in[gi]),
            .err_flag_out(err_flags[gi]),
            .dma_req_out(dma_req_out[gi])
        );
        assign err_word[`EVT_ERR_LSB + POS] = err_flags[gi];
    end
endgenerate

assign err_word[`EVT_ERR_LSB-1:0] = {`EVT_ERR_LSB{1'b0}};
assign err_word[`EVT_ERR_LSB+5] = 1'b0;
assign err_word[31:`EVT_ERR_LSB+8] = {(24-`EVT_ERR_LSB){1'b0}};

// ----------------------------------------
// events and interrupt
// ----------------------------------------
reg wake_evt_r;
reg [31:0] evt_en_r;
wire [31:0] status_word;
wire wake_req;

assign evt_clr_bits = (do_wr && wr_sel == SEL_ECLR) ? (wr_data & `EVT_STICKY_MASK) : 32'h00000000;
assign wake_req = ctrl_r[`CTRL_WAKE_ON] & (|sdin_s);

assign status_word = err_word
                   | ({31'h00000000, wake_evt_r} << `EVT_WAKE_BIT)
                   | ({31'h00000000, clk_alive_r} << `EVT_CLK_ALIVE_BIT);

always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        wake_evt_r <= 1'b0;
        evt_en_r <= `EVT_ENABLE_RESET;
        link_power_event_irq_out <= 1'b0;
        irq_out <= 1'b0;
    end else begin
        // a new wake event wins over a clear in the same cycle
        wake_evt_r <= wake_req | (wake_evt_r & ~evt_clr_bits[`EVT_WAKE_BIT]);
        if (do_wr && wr_sel == SEL_EEN) begin
            evt_en_r <= (evt_en_r & ~strb_mask(w_strb_r)) | (wr_data & `EVT_STICKY_MASK);
        end
        link_power_event_irq_out <= wake_req;
        irq_out <= |(status_word & evt_en_r & `EVT_STICKY_MASK);
    end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
wire ar_hs;
wire [2:0] rd_sel;
reg [31:0] rd_word;

assign ar_hs = s_axi_arvalid_in & s_axi_arready_out;
assign rd_sel = reg_sel(s_axi_araddr_in);

always @* begin
    case (rd_sel)
        SEL_SET: rd_word = ctrl_r;
        SEL_STAT: rd_word = status_word;
        SEL_EEN: rd_word = evt_en_r;
        default: rd_word = 32'h00000000;
    endcase
end

always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b0;
        s_axi_rdata_out <= 32'h00000000;
        s_axi_rresp_out <= `RESP_OKAY;
    end else begin
        if (ar_hs) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_arready_out <= 1'b0;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end else if (!s_axi_rvalid_out) begin
            s_axi_arready_out <= 1'b1;
        end
    end
end

endmodule

/* File: verification/link_ctrl_chk.sv */
/*
 * checker for the link control block: clear-register effects and dma halt.
 * assumes: bound to the controller top; one write or read under way at a time.
 */
`timescale 1ns/1ps
`include "link_ctrl_defs.vh"
module link_ctrl_chk #(
    parameter ADDR_WIDTH = 16,
    parameter CHANNELS = 7
) (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire s_axi_awvalid_in,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr_in,
    input wire s_axi_awready_out,
    input wire s_axi_wvalid_in,
    input wire [31:0] s_axi_wdata_in,
    input wire s_axi_wready_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_arvalid_in,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr_in,
    input wire s_axi_arready_out,
    input wire s_axi_rvalid_out,
    input wire [31:0] s_axi_rdata_out,
    input wire [CHANNELS-1:0] dma_need_in,
    input wire [CHANNELS-1:0] dma_err_in,
    input wire [CHANNELS-1:0] dma_req_out,
    input wire codec_cold_reset_n_out,
    input wire warm_reset_drive_out,
    input wire link_power_event_irq_out
);
    reg [ADDR_WIDTH-1:0] wa_r;
    reg [ADDR_WIDTH-1:0] ra_r;
    reg [31:0] wd_r;
    reg bvq_r;
    reg ho_r;
    wire done_w = s_axi_bvalid_out & ~bvq_r;
    wire clr_w = done_w && wa_r == `LINK_CONTROL_CLEAR_ADDR;
    wire set_w = done_w && wa_r == `LINK_CONTROL_SET_ADDR;
    // last write and read addresses, and the pcm channel halt-off state
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wa_r <= 0;
            ra_r <= 0;
            wd_r <= 0;
            bvq_r <= 1'b0;
            ho_r <= 1'b0;
        end else begin
            bvq_r <= s_axi_bvalid_out;
            if (s_axi_awvalid_in && s_axi_awready_out) wa_r <= s_axi_awaddr_in;
            if (s_axi_wvalid_in && s_axi_wready_out) wd_r <= s_axi_wdata_in;
            if (s_axi_arvalid_in && s_axi_arready_out) ra_r <= s_axi_araddr_in;
            if (set_w && wd_r[16]) ho_r <= 1'b1;
            if (clr_w && wd_r[16]) ho_r <= 1'b0;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_cold; clr_w && wd_r[0] |-> !codec_cold_reset_n_out; endproperty
    a_cold: assert property (p_cold) else $error("cold reset not driven");
    property p_hold; clr_w && !wd_r[0] |-> $stable(codec_cold_reset_n_out); endproperty
    a_hold: assert property (p_hold) else $error("zero bit changed state");
    property p_warm; clr_w && wd_r[3] |-> !warm_reset_drive_out; endproperty
    a_warm: assert property (p_warm) else $error("warm reset still driven");
    property p_dma; clr_w && wd_r[8] |-> ##1 !dma_req_out[0]; endproperty
    a_dma: assert property (p_dma) else $error("request after disable");
    property p_wake; clr_w && wd_r[2] |-> ##1 !link_power_event_irq_out; endproperty
    a_wake: assert property (p_wake) else $error("wake request after disable");
    property p_halt; dma_err_in[0] && !ho_r |=> !dma_req_out[0]; endproperty
    a_halt: assert property (p_halt) else $error("request after error");
    property p_go; dma_err_in[0] && ho_r && dma_need_in[0] && dma_req_out[0] |=> dma_req_out[0]; endproperty
    a_go: assert property (p_go) else $error("halted with halt off");
    property p_rdz; $rose(s_axi_rvalid_out) && ra_r == `LINK_CONTROL_CLEAR_ADDR |-> s_axi_rdata_out == 0; endproperty
    a_rdz: assert property (p_rdz) else $error("clear register read nonzero");
    c_cold: cover property (clr_w && wd_r[0]);
    c_go: cover property (dma_err_in[0] && ho_r);
    c_wake: cover property ($rose(link_power_event_irq_out));
endmodule

/* File: verification/codec_model.sv */
/*
 * codec side of the link: bit clock and serial data inputs.
 * assumes: run_in frames the bit clock; wake_in is the codec wake level.
 */
`timescale 1ns/1ps
module codec_model (
    // from bench
    input wire run_in,
    input wire [1:0] wake_in,
    // link pins
    output reg bit_clk_out,
    output wire [1:0] sdin_out
);
    // stands low between frames; odd offset keeps it off core clock edges
    initial begin
        bit_clk_out = 1'b0;
        #3.3;
        forever #32 bit_clk_out = run_in ? ~bit_clk_out : 1'b0;
    end
    // pulled low unless the codec asks for wake-up
    assign sdin_out = wake_in;
endmodule

/* File: verification/audio_link_control_clear_tb.sv */
/*
 * bench for the link control block over axi4-lite.
 * assumes: bready and rready stay high; one access at a time.
 */
`timescale 1ns/1ps
`include "link_ctrl_defs.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module audio_link_control_clear_tb;
    localparam adr_set = `LINK_CONTROL_SET_ADDR;
    localparam adr_clr = `LINK_CONTROL_CLEAR_ADDR;
    localparam adr_st = `LINK_EVENT_STATUS_ADDR;
    localparam adr_ec = `LINK_EVENT_CLEAR_ADDR;
    reg core_clk_in, arst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    reg s_axi_arvalid_in, s_axi_rready_in, run, h;
    reg [15:0] s_axi_awaddr_in, s_axi_araddr_in;
    reg [31:0] s_axi_wdata_in, rs, ex, d;
    reg [3:0] s_axi_wstrb_in;
    reg [6:0] dma_need_in, dma_err_in, hv;
    reg [1:0] wake, rsp;
    wire bit_clk_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    wire s_axi_arready_out, s_axi_rvalid_out;
    wire [1:0] sdin_in, s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire [6:0] dma_req_out;
    wire codec_cold_reset_n_out, warm_reset_drive_out, link_sleep_force_out;
    wire microphone_input_select_out, link_power_event_irq_out, irq_out;
    integer mismatches = 0, compares = 0, cyc = 0, k, c, b;
    audio_link_controller dut_u (.*);
    codec_model codec_u (.run_in(run), .wake_in(wake), .bit_clk_out(bit_clk_in), .sdin_out(sdin_in));
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task wr(input [15:0] a, input [31:0] v);
        begin
            s_axi_awaddr_in <= a;
            s_axi_wdata_in <= v;
            s_axi_awvalid_in <= 1'b1;
            s_axi_wvalid_in <= 1'b1;
            do begin
                @(posedge core_clk_in);
                if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
                if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            end while (!s_axi_bvalid_out);
            rsp = s_axi_bresp_out;
        end
    endtask
    task rd(input [15:0] a);
        begin
            s_axi_araddr_in <= a;
            s_axi_arvalid_in <= 1'b1;
            do begin
                @(posedge core_clk_in);
                if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            end while (!s_axi_rvalid_out);
            d = s_axi_rdata_out;
            rsp = s_axi_rresp_out;
        end
    endtask
    task close_out;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        {arst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in, run} = 0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, dma_need_in, dma_err_in, wake, ex} = 0;
        {s_axi_bready_in, s_axi_rready_in} = 2'h3;
        s_axi_wstrb_in = 4'hF;
        rs = 32'hA25F6F78;
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        @(posedge core_clk_in);
        `CHK("cold", 1'b0, codec_cold_reset_n_out)
        rd(adr_set);
        `CHK("ctrl", 32'h0, d)
        wr(16'h0100, 32'hFFFFFFFF);
        `CHK("bresp", `RESP_SLVERR, rsp)
        rd(16'h0100);
        `CHK("rresp", `RESP_SLVERR, rsp)
        `CHK("unmapped read", 32'h0, d)
        for (k = 0; k < 24; k++) begin
            repeat (130) @(posedge core_clk_in);
            rs = xs(rs);
            wr(adr_set, rs);
            ex = (ex | rs) & `CTRL_WRITE_MASK;
            repeat (130) @(posedge core_clk_in);
            rs = xs(rs);
            d = k == 0 ? 32'h0 : k == 23 ? 32'hFFFFFFFF : rs;
            wr(adr_clr, d);
            ex = ex & ~d;
            rd(adr_set);
            `CHK("ctrl", ex, d)
            `CHK("cold", ex[0], codec_cold_reset_n_out)
            `CHK("warm", ex[3], warm_reset_drive_out)
            `CHK("sleep", ex[1], link_sleep_force_out)
            `CHK("mic", ex[4], microphone_input_select_out)
            rd(adr_clr);
            `CHK("clr read", 32'h0, d)
            `CHK("clr rresp", `RESP_OKAY, rsp)
        end
        dma_need_in <= 7'h7F;
        for (k = 0; k < 14; k++) begin
            c = k % 7;
            b = c < 5 ? 8 + c : 9 + c;
            rs = xs(rs);
            h = k < 7 ? rs[0] : !hv[c];
            hv[c] = h;
            wr(adr_clr, 32'h00DFDF00);
            wr(adr_ec, 32'h0000DF04);
            wr(adr_set, (32'h1 << b) | ({31'h0, h} << (b + 8)));
            wr(`LINK_EVENT_ENABLE_ADDR, {31'h0, rs[1]} << b);
            repeat (3) @(posedge core_clk_in);
            `CHK("req", 1'b1, dma_req_out[c])
            dma_err_in[c] <= 1'b1;
            @(posedge core_clk_in);
            dma_err_in[c] <= 1'b0;
            repeat (3) @(posedge core_clk_in);
            `CHK("req halt", h, dma_req_out[c])
            `CHK("irq", rs[1], irq_out)
            rd(adr_st);
            `CHK("err flag", 1'b1, d[b])
            wr(adr_clr, 32'h1 << b);
            @(posedge core_clk_in);
            `CHK("req off", 1'b0, dma_req_out[c])
            wr(adr_ec, 32'h1 << b);
            rd(adr_st);
            `CHK("err clear", 1'b0, d[b])
        end
        wr(adr_set, 32'h4);
        wake <= 2'h1;
        repeat (5) @(posedge core_clk_in);
        `CHK("wake", 1'b1, link_power_event_irq_out)
        wr(adr_clr, 32'h4);
        @(posedge core_clk_in);
        `CHK("wake off", 1'b0, link_power_event_irq_out)
        rd(adr_st);
        `CHK("wake evt", 1'b1, d[`EVT_WAKE_BIT])
        wake <= 2'h0;
        run <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        rd(adr_st);
        `CHK("clk alive", 1'b1, d[31])
        run <= 1'b0;
        repeat (200) @(posedge core_clk_in);
        rd(adr_st);
        `CHK("clk idle", 1'b0, d[31])
        close_out;
    end
endmodule
bind audio_link_controller link_ctrl_chk #(.ADDR_WIDTH(ADDR_WIDTH), .CHANNELS(CHANNELS)) chk_u (.*);
